/* rtl/sic_top.sv */
`timescale 1ns/10ps
`include "sic_defines.svh"
module sic_top (
  // Clock, reset, enable.
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // Parallel source.
  input wire logic TRANSMIT_CLOCK,
  input wire logic [`SIC_DATA_W-1:0] DATA_IN,
  // Control pins.
  input wire logic CAPTURE_EDGE_SELECT,
  input wire logic LINE_DRIVER_ON,
  input wire logic TRANSMIT_SLEEP_N,
  input wire logic RESERVED_TIE_LOW_A,
  input wire logic RESERVED_TIE_LOW_B,
  input wire logic RESERVED_TIE_LOW_C,
  // Word stream towards the serializer core.
  output logic WORD_VALID,
  input wire logic WORD_READY,
  output logic [`SIC_DATA_W-1:0] WORD_DATA,
  // Line driver and status.
  output logic LINE_OE,
  output logic PLL_RUN,
  output logic PLL_LOCKED,
  output logic OVERFLOW,
  output logic RESERVED_FAULT
);
  sic_fifo_if fif ();
  sic_pkg::sic_state_t st_ff, nxt_st;
  logic [7:0] lock_cnt_ff, nxt_lock_cnt;
  logic transmit_clock_d_ff, nxt_transmit_clock_d;
  logic ovf_ff, nxt_ovf, rsv_ff, nxt_rsv;
  logic [`SIC_DATA_W-1:0] word_ff, nxt_word;
  logic cap_ff, nxt_cap, strobe, rise, fall;

  ////////////////////////////////////////////////////////////////////////
  // State decode shared by capture gating, line gating and status pins.
  function automatic logic pll_is_on(sic_pkg::sic_state_t s);
    return s != sic_pkg::SIC_SLEEP;
  endfunction

  // Capture is refused until lock, so words never race the PLL.
  function automatic logic pll_is_locked(sic_pkg::sic_state_t s);
    return s == sic_pkg::SIC_RUN;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Edge detect on the transmit clock, which is sampled as a plain input.
  always_comb begin
    rise = TRANSMIT_CLOCK && !transmit_clock_d_ff;
    fall = !TRANSMIT_CLOCK && transmit_clock_d_ff;
    strobe = CAPTURE_EDGE_SELECT ? rise : fall;
    nxt_transmit_clock_d = TRANSMIT_CLOCK;
    // Words are only taken while the PLL is locked; sleep drops them.
    nxt_cap = strobe && pll_is_locked(st_ff);
    nxt_word = nxt_cap ? DATA_IN : word_ff;
    // A capture that meets a full FIFO is lost and flagged until reset.
    nxt_ovf = ovf_ff || (cap_ff && !fif.wr_ready);
    nxt_rsv = RESERVED_TIE_LOW_A || RESERVED_TIE_LOW_B
              || RESERVED_TIE_LOW_C;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      transmit_clock_d_ff <= 1'b0;
      cap_ff <= 1'b0;
      word_ff <= `SIC_WORD_RST;
      ovf_ff <= 1'b0;
      rsv_ff <= 1'b0;
    end else if (CLK_EN) begin
      transmit_clock_d_ff <= nxt_transmit_clock_d;
      cap_ff <= nxt_cap;
      word_ff <= nxt_word;
      ovf_ff <= nxt_ovf;
      rsv_ff <= nxt_rsv;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power state: sleep stops the PLL, waking waits out the lock time.
  always_comb begin
    nxt_st = st_ff;
    nxt_lock_cnt = lock_cnt_ff;
    case (st_ff)
      sic_pkg::SIC_SLEEP: begin
        nxt_lock_cnt = 8'h00;
        if (TRANSMIT_SLEEP_N) begin
          nxt_st = sic_pkg::SIC_LOCKING;
        end
      end
      sic_pkg::SIC_LOCKING: begin
        nxt_lock_cnt = lock_cnt_ff + 8'h01;
        if (!TRANSMIT_SLEEP_N) begin
          nxt_st = sic_pkg::SIC_SLEEP;
        end else if (lock_cnt_ff == `SIC_LOCK_CYCLES - 8'h01) begin
          nxt_st = sic_pkg::SIC_RUN;
        end
      end
      sic_pkg::SIC_RUN: begin
        // Driver enable has no effect here: the PLL keeps its lock.
        if (!TRANSMIT_SLEEP_N) begin
          nxt_st = sic_pkg::SIC_SLEEP;
        end
      end
      default: begin
        nxt_st = sic_pkg::SIC_SLEEP;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_ff <= sic_pkg::SIC_SLEEP;
      lock_cnt_ff <= 8'h00;
    end else if (CLK_EN) begin
      st_ff <= nxt_st;
      lock_cnt_ff <= nxt_lock_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Captured words are buffered so the core can stall briefly.
  always_comb begin
    fif.wr_valid = cap_ff;
    fif.wr_data = word_ff;
    fif.rd_ready = WORD_READY && CLK_EN;
  end

  sic_fifo #(
    .WIDTH(`SIC_DATA_W),
    .DEPTH(`SIC_FIFO_DEPTH)
  ) i_sic_fifo (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .ce(CLK_EN),
    .f(fif.fifo)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs; the line is driven only when enabled and awake.
  always_comb begin
    WORD_VALID = fif.rd_valid;
    WORD_DATA = fif.rd_data;
    LINE_OE = LINE_DRIVER_ON && TRANSMIT_SLEEP_N
              && pll_is_on(st_ff);
    PLL_RUN = pll_is_on(st_ff);
    PLL_LOCKED = pll_is_locked(st_ff);
    OVERFLOW = ovf_ff;
    RESERVED_FAULT = rsv_ff;
  end
endmodule

/* rtl/sic_defines.svh */
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH

// Width of the parallel input word.
`define SIC_DATA_W 24
// Depth of the capture FIFO in words.
`define SIC_FIFO_DEPTH 32
// Reset value of the held captured word.
`define SIC_WORD_RST 24'h000000
// Cycles the PLL model needs to lock after wake-up (arbitrary, short).
`define SIC_LOCK_CYCLES 8'h10

`endif

/* rtl/sic_pkg.sv */
package sic_pkg;
  // Power and PLL lock state of the transmitter.
  typedef enum logic [1:0] {
    SIC_SLEEP,
    SIC_LOCKING,
    SIC_RUN
  } sic_state_t;
endpackage

/* rtl/sic_fifo_if.sv */
`timescale 1ns/10ps
`include "sic_defines.svh"
// Write and read channels of the capture FIFO.
interface sic_fifo_if;
  logic wr_valid;
  logic wr_ready;
  logic [`SIC_DATA_W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [`SIC_DATA_W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready,
                output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready,
                input wr_ready, rd_valid, rd_data);
endinterface

/* rtl/sic_fifo.sv */
`timescale 1ns/10ps
`include "sic_defines.svh"
// Synchronous FIFO with valid/ready on both sides.
module sic_fifo #(
  parameter int WIDTH = `SIC_DATA_W,
  parameter int DEPTH = `SIC_FIFO_DEPTH
) (
  // Clocking.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Channels.
  sic_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [WIDTH-1:0] rd_ff, nxt_rd;
  logic full, empty, push, pop;

  ////////////////////////////////////////////////////////////////////////
  // Flags use an extra pointer bit so full and empty never alias.
  always_comb begin
    full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    empty = (wp_ff == rp_ff);
    push = f.wr_valid && !full;
    pop = f.rd_ready && !empty;
    nxt_wp = push ? wp_ff + (AW+1)'(1) : wp_ff;
    nxt_rp = pop ? rp_ff + (AW+1)'(1) : rp_ff;
    // A word written into an emptied head bypasses the array; an empty
    // FIFO holds its last word so unwritten entries never reach the pins.
    if (push && nxt_rp == wp_ff) begin
      nxt_rd = f.wr_data;
    end else if (nxt_rp != wp_ff) begin
      nxt_rd = mem[nxt_rp[AW-1:0]];
    end else begin
      nxt_rd = rd_ff;
    end
    f.wr_ready = !full;
    f.rd_valid = !empty;
    f.rd_data = rd_ff;
  end

  // Head word is prefetched so read data comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
      rd_ff <= '0;
    end else if (ce) begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      if (push) begin
        mem[wp_ff[AW-1:0]] <= f.wr_data;
      end
      rd_ff <= nxt_rd;
    end
  end
endmodule

/* dv/sic_src_model.sv */
`timescale 1ns/10ps
`include "sic_defines.svh"
// Source: its clock toggles every 4 cycles while run is high.
module sic_src_model (
  // Control.
  input wire logic clk,
  input wire logic run,
  input wire logic [`SIC_DATA_W-1:0] base,
  // Pins.
  output logic transmit_clock,
  output logic [`SIC_DATA_W-1:0] data
);
  logic [1:0] cnt = 2'h0;
  logic [`SIC_DATA_W-1:0] h = '0;
  logic tog = 1'h0;
  // Data moves a cycle before each edge, so it is stable at both.
  always @(posedge clk) begin
    cnt <= run ? cnt + 2'h1 : 2'h0;
    h <= !run ? '0 : (cnt == 2'h2) ? h + 1'h1 : h;
    if (run && cnt == 2'h3) tog <= ~tog;
  end
  // The clock idles low outside bursts of an even edge count.
  assign transmit_clock = tog;
  // Every bit is driven, none floats.
  assign data = base + h;
endmodule

/* dv/sic_top_chk.sv */
`timescale 1ns/10ps
`include "sic_defines.svh"
// Capture, gating and power checks on the top pins.
module sic_top_chk (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Pins.
  input wire logic TRANSMIT_CLOCK,
  input wire logic [`SIC_DATA_W-1:0] DATA_IN,
  input wire logic CAPTURE_EDGE_SELECT,
  input wire logic LINE_DRIVER_ON,
  input wire logic TRANSMIT_SLEEP_N,
  input wire logic WORD_VALID,
  input wire logic [`SIC_DATA_W-1:0] WORD_DATA,
  input wire logic LINE_OE,
  input wire logic PLL_RUN,
  input wire logic PLL_LOCKED
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  chk_rise_word:
    assert property ($rose(TRANSMIT_CLOCK) && CAPTURE_EDGE_SELECT &&
      PLL_LOCKED && !WORD_VALID |-> ##3 WORD_VALID &&
      WORD_DATA == $past(DATA_IN, 3)) else $error("rise word lost");
  chk_fall_word:
    assert property ($fell(TRANSMIT_CLOCK) && !CAPTURE_EDGE_SELECT &&
      PLL_LOCKED && !WORD_VALID |-> ##3 WORD_VALID &&
      WORD_DATA == $past(DATA_IN, 3)) else $error("fall word lost");
  chk_wrong_edge:
    assert property (($rose(TRANSMIT_CLOCK) ^ CAPTURE_EDGE_SELECT) &&
      $changed(TRANSMIT_CLOCK) && PLL_LOCKED && !WORD_VALID |->
      ##3 !WORD_VALID) else $error("wrong edge captured");
  chk_oe_gate:
    assert property (LINE_OE |-> LINE_DRIVER_ON && TRANSMIT_SLEEP_N &&
      PLL_RUN) else $error("driver on while gated");
  chk_oe_on:
    assert property (LINE_DRIVER_ON && TRANSMIT_SLEEP_N && PLL_LOCKED
      |-> LINE_OE) else $error("driver stays off");
  chk_off_locked:
    assert property (!LINE_DRIVER_ON && TRANSMIT_SLEEP_N && PLL_LOCKED
      |=> PLL_LOCKED) else $error("lock lost with driver off");
  chk_sleep_stop:
    assert property (!TRANSMIT_SLEEP_N |=> !PLL_RUN && !LINE_OE)
      else $error("pll runs asleep");
  chk_lock_time:
    assert property ($rose(PLL_RUN) |-> ##15 !PLL_LOCKED ##1 PLL_LOCKED)
      else $error("lock time wrong");
  cover property ($rose(PLL_LOCKED));
  cover property ($fell(TRANSMIT_CLOCK) && !CAPTURE_EDGE_SELECT);
  cover property ($fell(PLL_RUN));
endmodule
bind sic_top sic_top_chk i_sic_top_chk (.CORE_CLK(CORE_CLK),
  .RESETN(RESETN), .TRANSMIT_CLOCK(TRANSMIT_CLOCK), .DATA_IN(DATA_IN),
  .CAPTURE_EDGE_SELECT(CAPTURE_EDGE_SELECT),
  .LINE_DRIVER_ON(LINE_DRIVER_ON), .TRANSMIT_SLEEP_N(TRANSMIT_SLEEP_N),
  .WORD_VALID(WORD_VALID), .WORD_DATA(WORD_DATA), .LINE_OE(LINE_OE),
  .PLL_RUN(PLL_RUN), .PLL_LOCKED(PLL_LOCKED));

/* dv/sic_top_test.sv */
`timescale 1ns/10ps
`include "sic_defines.svh"
// Bursts from the source, then drains and compares the words.
module sic_top_test;
  logic clk, rstn, sel, line_driver_on, awake, run, rdy, transmit_clock, vld, oe, prun, lck;
  logic ovf, rflt;
  logic [`SIC_DATA_W-1:0] din, wdat, base;
  int err_total, comparisons;
  sic_src_model i_sic_src_model (.clk(clk), .run(run), .base(base),
    .transmit_clock(transmit_clock), .data(din));
  sic_top i_sic_top (.CORE_CLK(clk), .RESETN(rstn), .CLK_EN(1'h1),
    .TRANSMIT_CLOCK(transmit_clock), .DATA_IN(din), .CAPTURE_EDGE_SELECT(sel),
    .LINE_DRIVER_ON(line_driver_on), .TRANSMIT_SLEEP_N(awake),
    .RESERVED_TIE_LOW_A(1'h0), .RESERVED_TIE_LOW_B(1'h0),
    .RESERVED_TIE_LOW_C(1'h0), .WORD_VALID(vld), .WORD_READY(rdy),
    .WORD_DATA(wdat), .LINE_OE(oe), .PLL_RUN(prun), .PLL_LOCKED(lck),
    .OVERFLOW(ovf), .RESERVED_FAULT(rflt));
  // Compares and counts.
  task automatic chk(logic [`SIC_DATA_W-1:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Runs n source clock edges with the given edge choice.
  task automatic burst(logic s, logic [`SIC_DATA_W-1:0] b, int n);
    @(posedge clk);
    sel <= s;
    base <= b;
    run <= 1'h1;
    repeat (n * 4) @(posedge clk);
    run <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
  // Pops n words; rising edges carry odd steps, falling even.
  task automatic drain(logic s, logic [`SIC_DATA_W-1:0] b, int n);
    for (int k = 0; k < n; k++) begin
      repeat (20) begin
        @(negedge clk);
        if (vld) break;
      end
      chk(wdat, b + 2 * k + (s ? 1 : 2));
      @(posedge clk) rdy <= 1'h1;
      @(posedge clk) rdy <= 1'h0;
    end
    @(negedge clk) chk(vld, 1'h0);
    $display("test drain %0d done", n);
  endtask
  // Verdict.
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Clock at 250 MHz.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Watchdog, far beyond the expected run.
  initial begin
    #40000;
    err_total++;
    wrap_up;
  end
  // Main sequence.
  initial begin
    {rstn, line_driver_on, awake, run, rdy, sel} = 6'h01;
    base = '0;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    repeat (2) @(posedge clk) awake <= 1'h0;
    @(negedge clk) chk(prun | oe, 1'h0);
    @(posedge clk) awake <= 1'h1;
    repeat (20) @(posedge clk);
    @(negedge clk) chk({lck, oe, rflt}, 3'h4);
    @(posedge clk) line_driver_on <= 1'h1;
    @(negedge clk) chk(oe, 1'h1);
    $display("test power-up done");
    burst(1'h1, 24'h100000, 8);
    drain(1'h1, 24'h100000, 4);
    burst(1'h0, 24'h200000, 8);
    drain(1'h0, 24'h200000, 4);
    burst(1'h1, 24'h300000, 80);
    @(negedge clk) chk(ovf, 1'h1);
    drain(1'h1, 24'h300000, 32);
    @(posedge clk) awake <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk) chk({prun, oe}, 2'h0);
    burst(1'h1, 24'h400000, 8);
    @(negedge clk) chk(vld, 1'h0);
    $display("test sleep done");
    // A mid-run reset clears the sticky flag and empties the buffer.
    @(posedge clk) rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    @(negedge clk) chk({ovf, vld, prun, lck}, 4'h0);
    $display("test reset done");
    wrap_up;
  end
endmodule
